// *** dv/fsp_properties.sv ***
// Purpose: Link checks for the flash sequencer.
// Assumes: Both ends are design code.
// Notes: Halt length is counted, not unrolled.
`timescale 1ns/10ps
module fsp_properties (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic ctrl_wr, // Code write
  input wire logic [7:0] ctrl_rd, // Control readback
  input wire logic store, // Store strobe
  input wire logic halt // Core stall
);
  logic [6:0] hcnt;
  // Cycles of halt so far; cheaper than a long repetition
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) hcnt <= 7'h00;
    else hcnt <= halt ? hcnt + 7'h01 : 7'h00;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  erase_start_a: assert property (store && ctrl_rd == 8'h03 |=> halt) else $error("no erase stall");
  write_start_a: assert property (store && ctrl_rd == 8'h05 |=> halt) else $error("no write stall");
  load_quick_a: assert property (store && ctrl_rd == 8'h01 |=> !halt && ctrl_rd == 8'h00)
    else $error("load stalled or left armed");
  halt_len_a: assert property ($fell(halt) |-> hcnt == 7'h50) else $error("stall length wrong");
  halt_max_a: assert property (halt |-> hcnt < 7'h50) else $error("stall too long");
  arm_hold_a: assert property (halt |-> ctrl_rd[0]) else $error("enable dropped early");
  done_clear_a: assert property ($fell(halt) |-> ctrl_rd == 8'h00) else $error("enable not cleared");
  store_order_a: assert property (ctrl_wr |=> store) else $error("store late");
  halt_quiet_a: assert property (halt |-> !store && !ctrl_wr) else $error("core ran while stalled");
endmodule

// *** dv/fsp_tb.sv ***
// Purpose: Drives the core end and reads the flash back.
// Assumes: Both ends joined by one link.
// Notes: Waits end on busy of both ends.
`timescale 1ns/10ps
module fsp_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic busy_c, busy_d;
  logic [7:0] cmd_code = 8'h00;
  logic [8:0] cmd_addr = 9'h000;
  logic [8:0] rd_addr = 9'h000;
  logic [15:0] cmd_data = 16'h0000;
  logic [15:0] rd_data;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  fsp_if fsp_if_i ();
  fsp_core_end fsp_core_end_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy_c), .lnk(fsp_if_i.core));
  fsp_dev_end fsp_dev_end_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .rd_addr(rd_addr),
    .rd_data(rd_data), .busy(busy_d), .lnk(fsp_if_i.dev));
  fsp_properties fsp_properties_i (.clk(clk), .reset_n(reset_n), .ctrl_wr(fsp_if_i.ctrl_wr),
    .ctrl_rd(fsp_if_i.ctrl_rd), .store(fsp_if_i.store), .halt(fsp_if_i.halt));
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // Hang guard, well above the roughly 800 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Stall may start a few cycles late, so skip ahead before polling busy
  task automatic cmd(input logic [7:0] c, input logic [8:0] a, input logic [15:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 200 && (busy_c || busy_d); i++) @(negedge clk);
    chk({15'h0000, busy_c || busy_d}, 16'h0000);
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk(rd_data, exp);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_buffer_first;
    for (int i = 15; i >= 0; i--) cmd(8'h01, {5'h03, 4'(i)}, 16'ha500 + 16'(i));
    cmd(8'h03, 9'h03f, 16'h0bad);
    cmd(8'h05, 9'h030, 16'h0bad);
    for (int i = 0; i < 16; i++) rd({5'h03, 4'(i)}, 16'ha500 + 16'(i));
    rd(9'h02f, 16'hffff);
  endtask
  task automatic t_erase_first;
    cmd(8'h03, 9'h035, 16'h0000);
    rd(9'h03a, 16'hffff);
    cmd(8'h03, 9'h05a, 16'h0000);
    rd(9'h057, 16'hffff);
    cmd(8'h01, 9'h052, 16'h1234);
    cmd(8'h05, 9'h050, 16'h0000);
    rd(9'h052, 16'h1234);
    rd(9'h053, 16'h0000);
    cmd(8'h05, 9'h050, 16'h0000);
    rd(9'h052, 16'h0000);
  endtask
  task automatic t_clear;
    cmd(8'h03, 9'h060, 16'h0000);
    cmd(8'h01, 9'h061, 16'h5a5a);
    cmd(8'h11, 9'h061, 16'h0000);
    cmd(8'h05, 9'h060, 16'h0000);
    rd(9'h061, 16'h0000);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    t_buffer_first();
    t_erase_first();
    t_clear();
    wrap_up();
  end
endmodule

// *** hdl/fsp_core_end.sv ***
// Purpose: Core side issuing control writes and store instructions.
// Assumes: User asserts one command pulse while not busy.
// Notes: Writes the code, then issues the store on the next cycle.
`timescale 1ns/10ps
`include "fsp_regs.svh"
module fsp_core_end import fsp_pkg::*; #(parameter int AW = 9, parameter int DW = 16) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic cmd_valid, // Command request pulse
  input wire logic [7:0] cmd_code, // Control code to write
  input wire logic [AW-1:0] cmd_addr, // Address pointer value
  input wire logic [DW-1:0] cmd_data, // Word to store
  output logic busy, // Command in progress
  fsp_if.core lnk // Link to sequencer
);
  logic pend;
  logic stored;
  logic [AW-1:0] addr;
  logic [DW-1:0] data;
  wire start = clk_en && cmd_valid && !busy;
  ////////////////////////////////////////////////////////////////
  // Store follows code write by one cycle, inside the window
  assign lnk.ctrl_wr = start;
  assign lnk.ctrl_data = cmd_code;
  assign lnk.store = pend && !stored; // R5 R12 R13
  assign lnk.addr = addr; // R7 R11
  assign lnk.store_data = data;
  assign busy = pend || lnk.halt; // R9
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 1'b0;
      stored <= 1'b0;
      addr <= '0;
      data <= '0;
    end else if (clk_en) begin
      if (start) begin
        pend <= 1'b1;
        stored <= 1'b0;
        addr <= cmd_addr;
        data <= cmd_data;
      end else if (pend && !stored) begin
        stored <= 1'b1;
      end else if (pend && !lnk.halt) begin
        pend <= 1'b0;
      end
    end
  end
endmodule

// *** hdl/fsp_dev_end.sv ***
// Purpose: Flash self-programming sequencer with page buffer and array.
// Assumes: Flash array is flip-flops; erase/write take fixed times.
// Notes: Halt holds the core while erase or write runs.
// Notes: Control register, arm window and timer advance only with clk_en.
// Notes: The page buffer survives an erase, so it may be filled either side.
// Notes: Erase and write address the page independently of each other.
`timescale 1ns/10ps
`include "fsp_regs.svh"
module fsp_dev_end import fsp_pkg::*; #(
  parameter int PAGES = 32,
  parameter int WPP = 16,
  parameter int DW = 16,
  parameter int PW = $clog2(PAGES),
  parameter int WW = $clog2(WPP),
  parameter int AW = PW + WW
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic [AW-1:0] rd_addr, // Flash read word address
  output logic [DW-1:0] rd_data, // Flash read word
  output logic busy, // Erase or write running
  fsp_if.dev lnk // Link from core
);
  // Operation lengths in cycles, rounded up so the array never finishes early
  localparam int ERASE_CYC = (`FSP_ERASE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS;
  localparam int WRITE_CYC = (`FSP_WRITE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS;
  localparam logic [15:0] ERASE_LOAD = 16'(ERASE_CYC - 1);
  localparam logic [15:0] WRITE_LOAD = 16'(WRITE_CYC - 1);
  logic [DW-1:0] buff [WPP];
  logic [DW-1:0] flash [PAGES*WPP];
  logic [7:0] ctrl;
  logic [2:0] arm;
  logic [15:0] tmr;
  logic [PW-1:0] page;
  fsp_state_e state;
  logic [7:0] next_ctrl;
  logic [2:0] next_arm;
  logic [15:0] next_tmr;
  logic [PW-1:0] next_page;
  fsp_state_e next_state;
  ////////////////////////////////////////////////////////////////
  // Codes the control register knows; any other write is dropped whole
  function automatic logic known_code(input logic [7:0] c);
    known_code = c == `FSP_CMD_LOAD || c == `FSP_CMD_ERASE || c == `FSP_CMD_WRITE || c == `FSP_CMD_CLEAR;
  endfunction
  // Codes that arm a following store; clear acts at once and never arms
  function automatic logic arming_code(input logic [7:0] c);
    arming_code = known_code(c) && c != `FSP_CMD_CLEAR;
  endfunction
  ////////////////////////////////////////////////////////////////
  // Command decode
  wire idle = state == FSP_IDLE;
  wire armed = ctrl[`FSP_CTRL_ENABLE_BIT] && arm != 3'h0 && arming_code(ctrl); // R15
  wire go = clk_en && armed && lnk.store && idle;
  wire do_load = go && ctrl == `FSP_CMD_LOAD; // R2 R12
  wire do_erase = go && ctrl == `FSP_CMD_ERASE; // R5
  wire do_write = go && ctrl == `FSP_CMD_WRITE; // R13
  // Writes while halted are dropped; a stalled core cannot issue them anyway
  wire take_code = lnk.ctrl_wr && arming_code(lnk.ctrl_data) && idle;
  wire do_clear = clk_en && lnk.ctrl_wr && lnk.ctrl_data == `FSP_CMD_CLEAR && idle;
  wire [PW-1:0] z_page = lnk.addr[AW-1:WW]; // R7 R8
  wire [WW-1:0] z_word = lnk.addr[WW-1:0]; // R4
  wire done = !idle && tmr == 16'h0;
  assign lnk.ctrl_rd = ctrl;
  assign lnk.halt = !idle; // R9
  assign busy = lnk.halt;
  ////////////////////////////////////////////////////////////////
  // Next-state logic; erase and write share one timed busy path
  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_arm = arm;
    next_tmr = tmr;
    next_page = page;
    case (state)
      FSP_IDLE: begin
        if (take_code) begin
          next_ctrl = lnk.ctrl_data;
          next_arm = `FSP_ARM_CYCLES; // R15
        end else if (do_erase) begin
          next_state = FSP_ERASE; // R1
          next_page = z_page; // R7 R8
          next_tmr = ERASE_LOAD;
        end else if (do_write) begin
          next_state = FSP_WRITE; // R13
          next_page = z_page; // R11
          next_tmr = WRITE_LOAD;
        end else if (do_load) begin
          next_ctrl = `FSP_CTRL_RESET; // R15
          next_arm = 3'h0;
        end else if (arm != 3'h0) begin
          next_arm = arm - 3'h1;
          if (arm == 3'h1) begin
            next_ctrl = `FSP_CTRL_RESET; // R15
          end
        end
      end
      FSP_ERASE, FSP_WRITE: begin
        // Enable stays set until the array work is over
        if (done) begin
          next_state = FSP_IDLE; // R9
          next_ctrl = `FSP_CTRL_RESET; // R15
          next_arm = 3'h0;
        end else begin
          next_tmr = tmr - 16'h1;
        end
      end
      default: begin
        next_state = FSP_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Sequencer state; frozen with the rest while clk_en is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= FSP_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end
  // Control register; only known codes land here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `FSP_CTRL_RESET;
    end else if (clk_en) begin
      ctrl <= next_ctrl;
    end
  end
  // Arm window; a late store finds it empty and is ignored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arm <= 3'h0;
    end else if (clk_en) begin
      arm <= next_arm;
    end
  end
  // Operation timer; counts down to the completion cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmr <= 16'h0;
    end else if (clk_en) begin
      tmr <= next_tmr;
    end
  end
  // Page latched at the store, so later pointer moves cannot retarget it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page <= '0;
    end else if (clk_en) begin
      page <= next_page;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Page buffer; erase leaves it intact, store data unused on erase
  for (genvar w = 0; w < WPP; w++) begin : g_buf
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        buff[w] <= '0; // R14
      end else if (do_clear || (clk_en && done && state == FSP_WRITE)) begin
        buff[w] <= '0; // R14
      end else if (do_load && z_word == WW'(w)) begin
        buff[w] <= lnk.store_data; // R2 R3 R4 R6
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Array; write ANDs buffer in, so an unerased page cannot gain ones
  // Limitation: a write to a page that was not erased first only clears bits
  // Completion waits for clk_en, so a frozen block never changes the array
  for (genvar f = 0; f < PAGES*WPP; f++) begin : g_arr
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        flash[f] <= `FSP_ERASED_WORD;
      end else if (clk_en && done && page == PW'(f / WPP)) begin
        if (state == FSP_ERASE) begin
          flash[f] <= `FSP_ERASED_WORD; // R16
        end else begin
          flash[f] <= flash[f] & buff[f % WPP]; // R1
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Read port; one cycle of latency, data comes from a flip-flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= flash[rd_addr];
    end
  end
endmodule

// *** hdl/fsp_if.sv ***
// Purpose: Link between the core end and the flash sequencer.
// Assumes: Single clock, both ends synchronous.
// Notes: Control write and store are one-cycle strobes.
`timescale 1ns/10ps
interface fsp_if #(parameter int AW = 9, parameter int DW = 16);
  logic ctrl_wr;
  logic [7:0] ctrl_data;
  logic [7:0] ctrl_rd;
  logic store;
  logic [AW-1:0] addr;
  logic [DW-1:0] store_data;
  logic halt;
  modport dev (input ctrl_wr, ctrl_data, store, addr, store_data, output ctrl_rd, halt);
  modport core (output ctrl_wr, ctrl_data, store, addr, store_data, input ctrl_rd, halt);
endinterface

// *** hdl/fsp_pkg.sv ***
// Purpose: Types for the flash self-programming page sequencer.
// Assumes: Constants live in fsp_regs.svh.
// Notes: Sequencer state only.
package fsp_pkg;
  typedef enum logic [1:0] {FSP_IDLE, FSP_ERASE, FSP_WRITE} fsp_state_e;
endpackage

// *** hdl/fsp_regs.svh ***
// Purpose: Constants for the flash self-programming page sequencer.
// Assumes: 16-bit words, 8-bit control register, 20 MHz clock.
// Notes: Shared by the device end and the core end.
// What the document requires
// (R1) Page must be erased before page write.
// (R2) One buffer word loaded per store instruction.
// (R3) Buffer loads allowed before or after erase.
// (R4) Buffer words loadable in any order.
// (R5) Erase code then store within four cycles.
// (R6) Erase ignores the store data bytes.
// (R7) Erase page comes from page-number field.
// (R8) Erase ignores non-page address pointer bits.
// (R9) Core stalled for whole erase duration.
// (R10) Software saves unchanged page remainder first.
// (R11) Same page number for erase and write.
// (R12) Load code then store loads one word.
// (R13) Write code then store writes page.
// (R14) Buffer clears on write, clear command, reset.
// (R15) Enable arms store for four cycles only.
// (R16) Erased page reads back all ones.
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_CMD_LOAD 8'h01
`define FSP_CMD_ERASE 8'h03
`define FSP_CMD_WRITE 8'h05
`define FSP_CMD_CLEAR 8'h11
`define FSP_CTRL_RESET 8'h00
`define FSP_CTRL_ENABLE_BIT 0
`define FSP_ARM_CYCLES 3'h4
`define FSP_ERASE_NS 32'd4000
`define FSP_WRITE_NS 32'd4000
`define FSP_CLK_NS 32'd50
`define FSP_ERASED_WORD 16'hffff
`endif
